// ==== sim/pdu_cpu.sv ====
// bus master model driving the unit's 8-bit byte port
// assumes a free-running clock and read data one cycle late
`timescale 1ns/1ns
module pdu_cpu (
	// clock
	input  wire logic       clk,
	// byte bus
	output logic      [2:0] bus_addr,
	output logic            bus_wr,
	output logic            bus_rd,
	output logic      [7:0] bus_wdata,
	input  wire logic [7:0] bus_rdata
);
	// idle bus at time zero
	initial begin
		bus_addr  = 3'h0;
		bus_wr    = 1'b0;
		bus_rd    = 1'b0;
		bus_wdata = 8'h00;
	end

	// one strobed byte; a released bus shows inverse address and data, strobes low
	task automatic cyc(input logic w, input logic [2:0] a,
		input logic [7:0] d, output logic [7:0] q);
		@(posedge clk);
		bus_addr  <= a;
		bus_wr    <= w;
		bus_rd    <= !w;
		bus_wdata <= d;
		@(posedge clk);
		bus_addr  <= ~a;
		bus_wr    <= 1'b0;
		bus_rd    <= 1'b0;
		bus_wdata <= ~d;
		@(negedge clk);
		q = bus_rdata;
	endtask

	task automatic wrw(input logic [2:0] a, input logic [15:0] v);
		logic [7:0] q;
		cyc(1'b1, a, v[15:8], q);
		cyc(1'b1, a + 3'h1, v[7:0], q);
	endtask

	task automatic rdw(input logic [2:0] a, output logic [15:0] v);
		cyc(1'b0, a, 8'h00, v[15:8]);
		cyc(1'b0, a + 3'h1, 8'h00, v[7:0]);
	endtask
endmodule

// ==== sim/pdu_top_bench.sv ====
// self-checking bench for the pulse-width d/a unit
// assumes pdu_cpu drives the byte port; addr 0/1 word a, 2/3 word b
`timescale 1ns/1ns
module pdu_top_bench;
	localparam int unsigned DIV_LONG = 16;
	logic        clk;
	logic        rstn;
	logic [2:0]  bus_addr;
	logic        bus_wr;
	logic        bus_rd;
	logic [7:0]  bus_wdata;
	logic [7:0]  bus_rdata;
	logic        channel_a_pin;
	logic        channel_b_pin;
	int          bad_count;
	int          num_checks;
	logic [15:0] w1;
	logic [15:0] w2;
	logic [7:0]  q;
	int          divs [7] = '{2, DIV_LONG, 64, 128, 256, 1024, 4096};
	logic [2:0]  codes [7] = '{3'h0, 3'h6, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5};

	pdu_top #(.DIV_LONGEST(DIV_LONG)) dut (
		.clk(clk), .rstn(rstn), .bus_addr(bus_addr), .bus_wr(bus_wr),
		.bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
		.channel_a_pin(channel_a_pin), .channel_b_pin(channel_b_pin));
	pdu_cpu cpu (
		.clk(clk), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
		.bus_wdata(bus_wdata), .bus_rdata(bus_rdata));

	// 100 ns clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// compare and count
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// verdict and end of run
	task automatic conclude();
		if (bad_count == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// byte write and checked byte read
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		cpu.cyc(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		cpu.cyc(1'b0, a, 8'h00, q);
		chk({8'h00, q}, {8'h00, e});
	endtask

	// counter steps between two word reads d cycles apart
	task automatic meas(input int d, input logic [13:0] n);
		cpu.rdw(3'h2, w1);
		repeat (d - 4) @(posedge clk);
		cpu.rdw(3'h2, w2);
		chk({2'b00, w2[15:2] - w1[15:2]}, {2'b00, n});
	endtask

	function automatic logic [7:0] sel_byte(input logic [2:0] c);
		return {2'b00, c[1], c[0], 3'b000, c[2]};
	endfunction

	// runaway guard, roughly three and a half times the expected run
	initial begin
		repeat (40000) @(posedge clk);
		bad_count++;
		conclude();
	end

	// test sequence
	initial begin
		rstn       = 1'b0;
		bad_count  = 0;
		num_checks = 0;
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		rd(3'h0, 8'h30); // control visible after reset
		rd(3'h4, 8'h00); // select starts at zero
		rd(3'h5, 8'h00); // hole reads zero
		wr(3'h0, 8'h0f);
		rd(3'h0, 8'h3f); // fixed ones kept
		wr(3'h0, 8'h00);
		rd(3'h0, 8'h30); // zero write clears low bits, fixed ones kept
		meas(40, 14'h0028); // one step per clock
		wr(3'h0, 8'h01);
		for (int i = 0; i < 7; i++) begin
			wr(3'h4, sel_byte(codes[i]));
			meas(2 * divs[i], 14'h0002); // divided steps
		end
		wr(3'h4, sel_byte(3'h7));
		meas(8, 14'h0000); // prohibited code freezes
		wr(3'h0, 8'h40);
		repeat (2) @(posedge clk);
		cpu.rdw(3'h2, w1);
		chk(w1, 16'h000f); // halted at three
		cpu.wrw(3'h2, 16'h0103);
		cpu.rdw(3'h2, w1);
		chk(w1, 16'h000f); // halt beats writes
		wr(3'h0, 8'h00);
		cpu.wrw(3'h2, 16'h0002);
		cpu.wrw(3'h0, 16'h1234);
		cpu.wrw(3'h2, 16'haa56);
		cpu.rdw(3'h0, w1);
		chk(w1, 16'h1235); // word committed
		wr(3'h0, 8'h55);
		cpu.rdw(3'h0, w1);
		chk(w1, 16'h1235); // upper write alone holds
		wr(3'h2, 8'h9a);
		wr(3'h1, 8'h10);
		cpu.rdw(3'h0, w1);
		chk(w1, 16'h9a11); // one latch for all words
		rd(3'h0, 8'h9a); // upper byte live
		rd(3'h3, 8'h11); // lower byte from latch
		cpu.rdw(3'h2, w1);
		chk(w1, 16'haa56); // byte sequence read back
		cpu.wrw(3'h0, 16'h0000);
		cpu.wrw(3'h2, 16'hfffd);
		for (int i = 0; i < 8; i++) begin
			wr(3'h0, {4'h4, i[2:0], 1'b0});
			repeat (2) @(posedge clk);
			@(negedge clk);
			chk({15'h0000, channel_a_pin}, {15'h0000, i[1] & ~i[0]});
			chk({15'h0000, channel_b_pin}, {15'h0000, i[2] & i[0]});
		end
		conclude();
	end
endmodule

// ==== src/pdu_pkg.sv ====
// constants shared by the pulse-width d/a unit: bus map, fields, resets
// assumes an 8-bit peripheral bus with byte addresses local to the unit
package pdu_pkg;
	// byte addresses on the unit's local bus
	localparam logic [2:0] ADDR_W0_HI   = 3'h0; // channel a data hi / control
	localparam logic [2:0] ADDR_W0_LO   = 3'h1; // channel a data lo
	localparam logic [2:0] ADDR_W1_HI   = 3'h2; // channel b data hi / counter hi
	localparam logic [2:0] ADDR_W1_LO   = 3'h3; // channel b data lo / counter lo
	localparam logic [2:0] ADDR_CLKSEL  = 3'h4; // peripheral clock select

	// pwm_dac_control fields
	localparam int          CTL_RUN_BIT = 6;  // counter_run_control
	localparam int          CTL_OEB_BIT = 3;  // channel_b_output_enable
	localparam int          CTL_OEA_BIT = 2;  // channel_a_output_enable
	localparam int          CTL_OS_BIT  = 1;  // output_phase_select
	localparam int          CTL_CKS_BIT = 0;  // resolution_source_select
	localparam logic [7:0]  CTL_FIXED   = 8'h30; // bits that read as one
	localparam logic [7:0]  CTL_RST     = 8'h30;

	// peripheral_clock_select fields
	localparam int          SEL_B0_BIT  = 4;  // resolution_select_bit0
	localparam int          SEL_B1_BIT  = 5;  // resolution_select_bit1
	localparam int          SEL_B2_BIT  = 0;  // resolution_select_bit2
	localparam logic [7:0]  CLKSEL_RST  = 8'h00;

	// 16-bit data and counter words
	localparam logic [15:0] DATA_RST    = 16'hFFFF;
	localparam logic [15:0] DATA_A_FIX  = 16'h0001; // reserved, reads one
	localparam int          REGS_BIT    = 0;  // register select in chan b
	localparam int          VAL_LSB     = 2;  // 14-bit value sits at 15:2
	localparam logic [13:0] CNT_RST     = 14'h0000;
	localparam logic [13:0] CNT_HALT    = 14'h0003;
	localparam logic [13:0] CNT_STEP    = 14'h0001;
	localparam logic [7:0]  UNMAPPED_RD = 8'h00;
	localparam logic [7:0]  LATCH_RST   = 8'h00;

	// resolution divisors for select codes 000..101, 110 is a top parameter
	localparam logic [14:0] DIV_C0      = 15'h0002;
	localparam logic [14:0] DIV_C1      = 15'h0040;
	localparam logic [14:0] DIV_C2      = 15'h0080;
	localparam logic [14:0] DIV_C3      = 15'h0100;
	localparam logic [14:0] DIV_C4      = 15'h0400;
	localparam logic [14:0] DIV_C5      = 15'h1000;
	localparam logic [14:0] DIV_NONE    = 15'h0000; // prohibited code
	localparam logic [2:0]  SEL_BAD     = 3'h7;
endpackage

// ==== src/pdu_tick.sv ====
// resolution prescaler: turns the system clock into the step tick
// assumes select inputs come from registers on the same clock
`timescale 1ns/1ns
module pdu_tick #(
	parameter int unsigned DIV_LONGEST = 16384
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// control and tick
	pdu_tick_if.gen  tif
);
	logic [14:0] pre_q;
	logic [14:0] pre_d;
	logic [14:0] div;
	logic        tick;

	// divisor lookup and prescale count
	always_comb begin
		case (tif.sel)
			3'h0: div = pdu_pkg::DIV_C0;
			3'h1: div = pdu_pkg::DIV_C1;
			3'h2: div = pdu_pkg::DIV_C2;
			3'h3: div = pdu_pkg::DIV_C3;
			3'h4: div = pdu_pkg::DIV_C4;
			3'h5: div = pdu_pkg::DIV_C5;
			3'h6: div = 15'(DIV_LONGEST);
			default: div = pdu_pkg::DIV_NONE;
		endcase
		pre_d = pre_q + 15'h0001;
		tick  = 1'b0;
		if (!tif.resolution_source_select) begin
			tick  = 1'b1;
			pre_d = 15'h0000;
		end else if (div == pdu_pkg::DIV_NONE) begin
			pre_d = 15'h0000;
		end else if (pre_q >= div - 15'h0001) begin
			tick  = 1'b1;
			pre_d = 15'h0000;
		end
	end

	// prescale register
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pre_q <= 15'h0000;
		end else begin
			pre_q <= pre_d;
		end
	end

	assign tif.tick = tick;
endmodule

// ==== src/pdu_tick_if.sv ====
// carrier between the register block and the resolution prescaler
// assumes both ends run on the same clock
`timescale 1ns/1ns
interface pdu_tick_if;
	logic       resolution_source_select;  // 0: tick every cycle, 1: divided tick
	logic [2:0] sel;  // {bit2, bit1, bit0} resolution select code
	logic       tick; // one resolution step

	modport ctl (output resolution_source_select, output sel, input tick);
	modport gen (input resolution_source_select, input sel, output tick);
endinterface

// ==== src/pdu_top.sv ====
// pulse-width d/a unit: control, clock select, counter, 8-bit bus port
// assumes the bus master issues one-cycle read or write strobes
// Operation
// - run bit clear counts up, set holds three
// - control bits five, four read one
// - control bit three gates channel b pin
// - control bit two gates channel a pin
// - phase bit inverts enabled channel waveforms
// - source bit clear: tick every clock
// - source bit set: select code sets divisor
// - upper byte write only fills latch
// - lower byte write commits whole word
// - upper byte read copies lower into latch
// - lower byte read returns latched byte
// - register select bit swaps shared addresses
`timescale 1ns/1ns
module pdu_top #(
	parameter int unsigned DIV_LONGEST = 16384
) (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rstn,
	// peripheral bus
	input  wire logic [2:0] bus_addr,
	input  wire logic       bus_wr,
	input  wire logic       bus_rd,
	input  wire logic [7:0] bus_wdata,
	output logic      [7:0] bus_rdata,
	// output pins
	output logic            channel_a_pin,
	output logic            channel_b_pin
);
	logic [7:0]  ctl_q;
	logic [7:0]  ctl_d;
	logic [7:0]  clksel_q;
	logic [7:0]  clksel_d;
	logic [15:0] data_a_q;
	logic [15:0] data_a_d;
	logic [15:0] data_b_q;
	logic [15:0] data_b_d;
	logic [13:0] cnt_q;
	logic [13:0] cnt_d;
	logic [7:0]  latch_q;
	logic [7:0]  latch_d;
	logic [7:0]  rdata_q;
	logic [7:0]  rdata_d;
	logic        pin_a_q;
	logic        pin_a_d;
	logic        pin_b_q;
	logic        pin_b_d;
	logic        regsel;
	logic [15:0] cnt_word;
	logic [15:0] wr_word;
	logic        cnt_wr;
	logic        wave_a;
	logic        wave_b;
	logic        chk_arm_q;
	logic        chk_arm_d;

	// counter value seen right after a wrap
	localparam logic [13:0] CNT_ZERO = 14'h0000;

	pdu_tick_if tif ();

	// resolution prescaler
	pdu_tick #(
		.DIV_LONGEST (DIV_LONGEST)
	) u_tick (
		.clk  (clk),
		.rstn (rstn),
		.tif  (tif)
	);

	assign tif.resolution_source_select = ctl_q[pdu_pkg::CTL_CKS_BIT];
	assign tif.sel = {clksel_q[pdu_pkg::SEL_B2_BIT],
			  clksel_q[pdu_pkg::SEL_B1_BIT],
			  clksel_q[pdu_pkg::SEL_B0_BIT]};

	assign regsel   = data_b_q[pdu_pkg::REGS_BIT];
	assign cnt_word = {cnt_q, 1'b1, data_b_q[pdu_pkg::REGS_BIT]};
	assign wr_word  = {latch_q, bus_wdata};
	assign cnt_wr   = bus_wr && regsel &&
			  (bus_addr == pdu_pkg::ADDR_W1_LO);

	// register, latch and counter next values
	always_comb begin
		ctl_d    = ctl_q;
		clksel_d = clksel_q;
		data_a_d = data_a_q;
		data_b_d = data_b_q;
		latch_d  = latch_q;
		cnt_d    = cnt_q;
		if (ctl_q[pdu_pkg::CTL_RUN_BIT]) begin
			cnt_d = pdu_pkg::CNT_HALT;
		end else if (tif.tick) begin
			cnt_d = cnt_q + pdu_pkg::CNT_STEP;
		end
		if (bus_wr) begin
			case (bus_addr)
				pdu_pkg::ADDR_W0_HI: begin
					if (regsel) begin
						ctl_d = bus_wdata | pdu_pkg::CTL_FIXED;
					end else begin
						latch_d = bus_wdata;
					end
				end
				pdu_pkg::ADDR_W0_LO: begin
					if (!regsel) begin
						data_a_d = wr_word | pdu_pkg::DATA_A_FIX;
					end
				end
				pdu_pkg::ADDR_W1_HI: begin
					latch_d = bus_wdata;
				end
				pdu_pkg::ADDR_W1_LO: begin
					if (!regsel) begin
						data_b_d = wr_word;
					end else begin
						if (!ctl_q[pdu_pkg::CTL_RUN_BIT]) begin
							cnt_d = wr_word[15:pdu_pkg::VAL_LSB];
						end
						data_b_d[pdu_pkg::REGS_BIT] =
							bus_wdata[pdu_pkg::REGS_BIT];
					end
				end
				pdu_pkg::ADDR_CLKSEL: begin
					clksel_d = bus_wdata;
				end
				default: begin
				end
			endcase
		end else if (bus_rd) begin
			case (bus_addr)
				pdu_pkg::ADDR_W0_HI: begin
					if (!regsel) begin
						latch_d = data_a_q[7:0];
					end
				end
				pdu_pkg::ADDR_W1_HI: begin
					latch_d = regsel ? cnt_word[7:0] : data_b_q[7:0];
				end
				default: begin
				end
			endcase
		end
	end

	// read data next value
	always_comb begin
		rdata_d = rdata_q;
		if (bus_rd) begin
			case (bus_addr)
				pdu_pkg::ADDR_W0_HI: begin
					rdata_d = regsel ? ctl_q : data_a_q[15:8];
				end
				pdu_pkg::ADDR_W0_LO: begin
					rdata_d = regsel ? pdu_pkg::UNMAPPED_RD : latch_q;
				end
				pdu_pkg::ADDR_W1_HI: begin
					rdata_d = regsel ? cnt_word[15:8] : data_b_q[15:8];
				end
				pdu_pkg::ADDR_W1_LO: begin
					rdata_d = latch_q;
				end
				pdu_pkg::ADDR_CLKSEL: begin
					rdata_d = clksel_q;
				end
				default: begin
					rdata_d = pdu_pkg::UNMAPPED_RD;
				end
			endcase
		end
	end

	// waveform: low while counter is below the data value
	assign wave_a = cnt_q >= data_a_q[15:pdu_pkg::VAL_LSB];
	assign wave_b = cnt_q >= data_b_q[15:pdu_pkg::VAL_LSB];

	// pin next values
	always_comb begin
		pin_a_d = 1'b0;
		pin_b_d = 1'b0;
		if (ctl_q[pdu_pkg::CTL_OEA_BIT]) begin
			pin_a_d = wave_a ^ ctl_q[pdu_pkg::CTL_OS_BIT];
		end
		if (ctl_q[pdu_pkg::CTL_OEB_BIT]) begin
			pin_b_d = wave_b ^ ctl_q[pdu_pkg::CTL_OS_BIT];
		end
	end

	// state registers
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctl_q    <= pdu_pkg::CTL_RST;
			clksel_q <= pdu_pkg::CLKSEL_RST;
			data_a_q <= pdu_pkg::DATA_RST;
			data_b_q <= pdu_pkg::DATA_RST;
			cnt_q    <= pdu_pkg::CNT_RST;
			latch_q  <= pdu_pkg::LATCH_RST;
			rdata_q  <= pdu_pkg::UNMAPPED_RD;
			pin_a_q  <= 1'b0;
			pin_b_q  <= 1'b0;
			chk_arm_q <= 1'b0;
		end else begin
			ctl_q    <= ctl_d;
			clksel_q <= clksel_d;
			data_a_q <= data_a_d;
			data_b_q <= data_b_d;
			cnt_q    <= cnt_d;
			latch_q  <= latch_d;
			rdata_q  <= rdata_d;
			pin_a_q  <= pin_a_d;
			pin_b_q  <= pin_b_d;
			chk_arm_q <= chk_arm_d;
		end
	end

	assign bus_rdata     = rdata_q;
	assign channel_a_pin = pin_a_q;
	assign channel_b_pin = pin_b_q;

	// checks stay off on the release edge itself, where reset and
	// the first sampled state disagree; armed from the next edge on
	assign chk_arm_d = rstn;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!chk_arm_q);

	cnt_halt_a: assert property (
		ctl_q[pdu_pkg::CTL_RUN_BIT] |=> cnt_q == pdu_pkg::CNT_HALT)
		else $error("counter not held at three");

	cnt_up_a: assert property (
		!ctl_q[pdu_pkg::CTL_RUN_BIT] && tif.tick && !cnt_wr
		|=> cnt_q == $past(cnt_q) + pdu_pkg::CNT_STEP)
		else $error("counter did not step");

	fixed_bits_a: assert property (
		bus_rd && regsel && bus_addr == pdu_pkg::ADDR_W0_HI
		|=> bus_rdata[5:4] == 2'b11)
		else $error("control bits five and four not one");

	pin_b_gate_a: assert property (
		!ctl_q[pdu_pkg::CTL_OEB_BIT] |=> !channel_b_pin)
		else $error("channel b driven while disabled");

	pin_a_gate_a: assert property (
		!ctl_q[pdu_pkg::CTL_OEA_BIT] |=> !channel_a_pin)
		else $error("channel a driven while disabled");

	phase_sel_a: assert property (
		ctl_q[pdu_pkg::CTL_OEA_BIT]
		|=> channel_a_pin == ($past(wave_a) ^
				      $past(ctl_q[pdu_pkg::CTL_OS_BIT])))
		else $error("channel a phase wrong");

	tick_fast_a: assert property (
		!ctl_q[pdu_pkg::CTL_CKS_BIT] |-> tif.tick)
		else $error("no tick with undivided source");

	tick_div2_a: assert property (
		tif.tick && tif.resolution_source_select && tif.sel == 3'h0
		##1 tif.resolution_source_select && tif.sel == 3'h0
		##1 tif.resolution_source_select && tif.sel == 3'h0
		|-> tif.tick && !$past(tif.tick))
		else $error("divide by two period wrong");

	tick_stop_a: assert property (
		tif.resolution_source_select && tif.sel == pdu_pkg::SEL_BAD |-> !tif.tick)
		else $error("tick on prohibited code");

	latch_only_a: assert property (
		bus_wr && bus_addr == pdu_pkg::ADDR_W1_HI
		|=> latch_q == $past(bus_wdata) && data_b_q == $past(data_b_q))
		else $error("upper byte write not latched only");

	word_join_a: assert property (
		bus_wr && !regsel && bus_addr == pdu_pkg::ADDR_W1_LO
		|=> data_b_q == {$past(latch_q), $past(bus_wdata)})
		else $error("lower byte write did not commit word");

	rd_latch_a: assert property (
		bus_rd && !bus_wr && !regsel && bus_addr == pdu_pkg::ADDR_W0_HI
		|=> latch_q == $past(data_a_q[7:0]))
		else $error("upper read did not latch lower byte");

	rd_low_a: assert property (
		bus_rd && bus_addr == pdu_pkg::ADDR_W1_LO
		|=> bus_rdata == $past(latch_q))
		else $error("lower read not from latch");

	word_write_c: cover property (
		bus_wr && bus_addr == pdu_pkg::ADDR_W1_HI
		##1 bus_wr && bus_addr == pdu_pkg::ADDR_W1_LO);
	word_read_c: cover property (
		bus_rd && bus_addr == pdu_pkg::ADDR_W0_HI
		##1 bus_rd && bus_addr == pdu_pkg::ADDR_W0_LO);
	inverted_pin_c: cover property (
		ctl_q[pdu_pkg::CTL_OS_BIT] && channel_b_pin);
	cnt_wrap_c: cover property (cnt_q == 14'h3FFF ##1 cnt_q == CNT_ZERO);
endmodule
